// *** inc/sar_map.vh ***
// How it works
// - Chain select low means normal mode; shared pin gates the serial output.
// - Chain select high means chain mode; shared pin carries upstream serial data.
// - Range pin high gives full span; low compresses codes into 18.75 to 81.25 percent.
// - A convert_start rising edge while not busy powers up and starts a new conversion.
// - Busy rises when a conversion starts and falls once it completes.
// - Normal mode with read enable low presents the result on the serial output.
// - Normal mode with read enable high floats the output and ignores the clock.
// - When enabled, each rising serial clock edge shifts one bit, MSB first.
// - In chain mode, upstream data follows the own result on the output.
// - Results are two's complement.
// - Each conversion hands a 24-bit raw code to the averaging filter.
// - The filter averages 1 to 65536 consecutive results into one word.
// - No programming port or configuration register; pins select everything.
// - Between conversions the converter powers down until the next start edge.
// - The span of twice the reference splits into 2 to the 24 codes.
`ifndef SAR_MAP_VH
`define SAR_MAP_VH
`define SAR_CLK_MHZ 40
`define SAR_CODE_W 24
`define SAR_SUM_W 40
`define SAR_CNT_W 17
`define SAR_CONV_NS 392
`define SAR_CONV_CYC ((`SAR_CONV_NS * `SAR_CLK_MHZ) / 1000)
`define SAR_QUIET_NS 10
`define SAR_MAX_AVG 65536
`define SAR_FS_POS 24'h7FFFFF
`define SAR_CMP_NUM 4
`define SAR_CMP_SHIFT 3
`endif

// *** rtl/sar_avg.v ***
`timescale 1ns/100ps
`include "sar_map.vh"
module sar_avg (
    input wire clk,
    input wire rst,
    input wire [4:0] avg_log2,
    input wire code_vld,
    input wire [23:0] code,
    input wire flush,
    output reg [23:0] avg_q,
    output reg [16:0] count_q
);
reg [39:0] sum_q;
wire [39:0] code_ext = {{16{code[23]}}, code};
wire [39:0] sum_n = sum_q + code_ext;
wire [16:0] cnt_n = count_q + 17'h00001;
wire [16:0] target = 17'h00001 << avg_log2;
wire [39:0] shifted = $signed(sum_n) >>> avg_log2;
// accumulate up to 2^16 codes, then emit their mean
always @(posedge clk) begin
    if (rst) begin
        sum_q <= 40'h0000000000;
        count_q <= 17'h00000;
        avg_q <= 24'h000000;
    end else if (flush) begin
        sum_q <= 40'h0000000000;
        count_q <= 17'h00000;
    end else if (code_vld) begin
        if (cnt_n >= target) begin
            avg_q <= shifted[23:0];
            sum_q <= 40'h0000000000;
            count_q <= 17'h00000;
        end else begin
            sum_q <= sum_n;
            count_q <= cnt_n;
        end
    end
end
endmodule // sar_avg

// *** rtl/sar_adc_serial_readout.v ***
`timescale 1ns/100ps
`include "sar_map.vh"
module sar_adc_serial_readout (
    input wire clk,
    input wire rst,
    input wire chain_sel,
    input wire range_select_pin,
    input wire convert_start,
    input wire read_enable_or_chain_in,
    input wire sck,
    input wire [23:0] sample_code,
    input wire [4:0] avg_log2,
    output reg busy_q,
    output reg power_on_q,
    output reg sdo_q,
    output wire sdo_oe
);
localparam ST_IDLE = 2'd0;
localparam ST_CONV = 2'd1;
localparam ST_DONE = 2'd2;
localparam integer CONV_I = `SAR_CONV_CYC;
// Conversion length in clocks, cut to the timer width on purpose
localparam [15:0] CONV_CYC = CONV_I[15:0];

// pins select everything
// Every mode comes from a pin level or the convert edge; no register
// port exists, so nothing here needs a bus decoder or a reset image.

// Three-stage sync; decisions use only stages 2 and 3
// All five pins come from outside the clock domain, the serial clock too
reg [2:0] cnv_s, rdl_s, sck_s, chn_s, rng_s;
always @(posedge clk) begin
    if (rst) begin
        cnv_s <= 3'h0;
        rdl_s <= 3'h7;
        sck_s <= 3'h0;
        chn_s <= 3'h0;
        rng_s <= 3'h7;
    end else begin
        cnv_s <= {cnv_s[1:0], convert_start};
        rdl_s <= {rdl_s[1:0], read_enable_or_chain_in};
        sck_s <= {sck_s[1:0], sck};
        chn_s <= {chn_s[1:0], chain_sel};
        rng_s <= {rng_s[1:0], range_select_pin};
    end
end
reg cnv_l_q, sck_l_q, rdl_l_q, chn_l_q, rng_l_q;

// Level updates only when stages agree, filtering one-cycle glitches
// Reset values match the idle pin levels, so no false edge follows reset
always @(posedge clk) begin
    if (rst) begin
        cnv_l_q <= 1'b0;
        sck_l_q <= 1'b0;
        rdl_l_q <= 1'b1;
        chn_l_q <= 1'b0;
        rng_l_q <= 1'b1;
    end else begin
        if (cnv_s[1] == cnv_s[2]) cnv_l_q <= cnv_s[2];
        if (sck_s[1] == sck_s[2]) sck_l_q <= sck_s[2];
        if (rdl_s[1] == rdl_s[2]) rdl_l_q <= rdl_s[2];
        if (chn_s[1] == chn_s[2]) chn_l_q <= chn_s[2];
        if (rng_s[1] == rng_s[2]) rng_l_q <= rng_s[2];
    end
end

// Edge pulses last one clock: the agreed level is new and the old is low
// A serial clock above a quarter of clk would be missed; this is the cost
// of sampling the link clock rather than clocking logic from it.
wire cnv_rise = (cnv_s[1] == cnv_s[2]) && cnv_s[2] && !cnv_l_q;
wire sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_l_q;
// normal mode, shared pin is active-low read enable
wire read_enable_n = rdl_l_q;

// chain mode, shared pin is upstream data
// Keep the sample from one clock before the detected clock edge:
// the upstream part moves its data just after that same edge, so the
// newest sample would already hold the next bit.
reg chain_in_q;
always @(posedge clk) begin
    if (rst) begin
        chain_in_q <= 1'b0;
    end else begin
        chain_in_q <= rdl_s[2];
    end
end
wire chain_in = chain_in_q;

// enable output in chain mode, or in normal mode with read enable low; float otherwise
wire out_en = chn_l_q ? 1'b1 : !read_enable_n;
assign sdo_oe = out_en;
reg [1:0] st_q;
reg [15:0] tmr_q;
reg [23:0] raw_q;
reg raw_vld_q;
reg [23:0] shreg_q;

// edge starts power-up and busy; timer ends it, then power down
// Start edges while busy are ignored; the host must pace its requests.
// Busy stays high for the counted conversion plus the done state, so the
// result is already on its way to the filter when busy falls.
always @(posedge clk) begin
    if (rst) begin
        st_q <= ST_IDLE;
        tmr_q <= 16'h0000;
        busy_q <= 1'b0;
        power_on_q <= 1'b0;
        raw_vld_q <= 1'b0;
        raw_q <= 24'h000000;
    end else begin
        raw_vld_q <= 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (cnv_rise) begin
                    st_q <= ST_CONV;
                    busy_q <= 1'b1;
                    power_on_q <= 1'b1;
                    tmr_q <= 16'h0000;
                end
            end
            ST_CONV: begin
                if (tmr_q >= CONV_CYC - 16'h0001) begin
                    st_q <= ST_DONE;
                    // 24-bit code, compressed when range pin low
                    raw_q <= rng_l_q ? sample_code : compress(sample_code);
                    raw_vld_q <= 1'b1;
                end else begin
                    tmr_q <= tmr_q + 16'h0001;
                end
            end
            ST_DONE: begin
                busy_q <= 1'b0;
                power_on_q <= 1'b0;
                st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
        endcase
    end
end

// scale signed code by 5/8 for the 18.75 to 81.25 percent span
// The product is taken modulo 2^27, which keeps the sign right for two's
// complement; dropping three bits floors towards minus infinity.
function [23:0] compress;
    input [23:0] c;
    reg [26:0] p;
    begin
        p = {{3{c[23]}}, c} * 27'd5;
        compress = p[26:3];
    end
endfunction

// Filter output; holds the last mean until the next count completes
wire [23:0] avg_word;
sar_avg u_avg (
    .clk(clk),
    .rst(rst),
    .avg_log2(avg_log2),
    .code_vld(raw_vld_q),
    .code(raw_q),
    .flush(1'b0),
    .avg_q(avg_word),
    .count_q()
);

reg load_q;
// Load the shift register when busy falls
// One clock later than the done state, so the filter has its new word
always @(posedge clk) begin
    if (rst) begin
        load_q <= 1'b0;
    end else begin
        load_q <= (st_q == ST_DONE);
    end
end

// two's complement MSB first, chain data fills behind
// The MSB shows right after the load; each rise then brings the next bit.
// In normal mode zeros fill behind, so extra clocks read back zeros.
always @(posedge clk) begin
    if (rst) begin
        shreg_q <= 24'h000000;
        sdo_q <= 1'b0;
    end else if (load_q) begin
        shreg_q <= avg_word;
        sdo_q <= avg_word[23];
    end else if (sck_rise && out_en) begin
        shreg_q <= {shreg_q[22:0], chn_l_q ? chain_in : 1'b0};
        sdo_q <= shreg_q[22];
    end
end
endmodule // sar_adc_serial_readout

// *** dv/sar_adc_serial_readout_assertions.sv ***
`timescale 1ns/100ps
module sar_chk (
    input wire clk,
    input wire rst,
    input wire chain_sel,
    input wire convert_start,
    input wire read_enable_or_chain_in,
    input wire sck,
    input wire busy_q,
    input wire power_on_q,
    input wire sdo_q,
    input wire sdo_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_oe_off: assert property ((!chain_sel && read_enable_or_chain_in)[*5] |-> !sdo_oe)
        else $error("oe on");
    chk_oe_on: assert property ((!chain_sel && !read_enable_or_chain_in)[*5] |-> sdo_oe)
        else $error("oe off");
    chk_busy_start: assert property ($rose(convert_start) && !busy_q |-> ##[2:6] busy_q)
        else $error("no busy");
    chk_busy_len: assert property ($rose(busy_q) |-> busy_q[*8] ##[1:12] !busy_q)
        else $error("busy len");
    chk_busy_cause: assert property ($rose(busy_q) |-> $past(convert_start, 2))
        else $error("busy cause");
    chk_pwr_busy: assert property (busy_q |-> power_on_q)
        else $error("pwr off");
    chk_pwr_down: assert property ($fell(busy_q) |-> ##[0:2] !power_on_q)
        else $error("pwr on");
    // Output moves only on a shift or reload
    chk_sdo_hold: assert property (($stable(sck) && !busy_q)[*6] |-> $stable(sdo_q))
        else $error("sdo moved");
    cover property ($fell(busy_q));
    cover property (chain_sel && sdo_oe);
    cover property ($rose(sck) && sdo_oe);
endmodule // sar_chk
bind sar_adc_serial_readout sar_chk u_chk (.clk, .rst, .chain_sel, .convert_start,
    .read_enable_or_chain_in, .sck, .busy_q, .power_on_q, .sdo_q, .sdo_oe);

// *** dv/sar_up_model.sv ***
`timescale 1ns/100ps
module sar_up_model (
    input wire sck,
    input wire load,
    input wire [23:0] word,
    output wire sdi
);
    reg [23:0] sh_q;
    // upstream word, shifted just after each rise like a real part
    always @(posedge sck or posedge load) begin
        if (load) sh_q <= word;
        else sh_q <= #2 {sh_q[22:0], ~sh_q[0]};
    end
    assign sdi = sh_q[23];
endmodule // sar_up_model

// *** dv/tb_sar_adc_serial_readout.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_sar_adc_serial_readout;
    reg clk = 0, rst = 1, chain_sel = 0, range_select_pin = 1, convert_start = 0;
    reg rd_n = 0, sck = 0, load = 0;
    reg [23:0] sample_code = 24'h000000;
    reg [47:0] got;
    wire busy_q, power_on_q, sdo_q, sdo_oe, up_sdi;
    int err_total = 0, n_checks = 0, r;
    // Range, raw code, expected word
    reg [48:0] rows [4] = '{{1'h1, 24'h7FFFFF, 24'h7FFFFF}, {1'h1, 24'h800000, 24'h800000},
        {1'h0, 24'h000008, 24'h000005}, {1'h0, 24'hFFFFF8, 24'hFFFFFB}};
    initial begin
        forever #12.5 clk = ~clk;
    end
    sar_adc_serial_readout dut (.clk(clk), .rst(rst), .chain_sel(chain_sel),
        .range_select_pin(range_select_pin), .convert_start(convert_start),
        .read_enable_or_chain_in(chain_sel ? up_sdi : rd_n), .sck(sck),
        .sample_code(sample_code), .avg_log2(5'h00), .busy_q(busy_q),
        .power_on_q(power_on_q), .sdo_q(sdo_q), .sdo_oe(sdo_oe));
    sar_up_model up (.sck(sck), .load(load), .word(24'hA5C30F), .sdi(up_sdi));
    task complete_run;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // start, keep sck quiet, wait for busy low
    task conv(input [23:0] code);
        int k;
        @(posedge clk);
        sample_code <= code;
        convert_start <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(busy_q, 1'b1)
        `CHK(power_on_q, 1'b1)
        convert_start <= 1'b0;
        for (k = 0; k < 99 && busy_q !== 1'b0; k++) @(posedge clk);
        `CHK(busy_q, 1'b0)
        `CHK(power_on_q, 1'b0)
        repeat (6) @(posedge clk);
    endtask
    // Bit sampled before each sck rise, 200 ns period
    task rd(input int n);
        int k;
        got = 48'h000000000000;
        for (k = 0; k < n; k++) begin
            got = {got[46:0], sdo_q};
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    initial begin
        #200000;
        err_total++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(busy_q, 1'b0)
        `CHK(power_on_q, 1'b0)
        `CHK(sdo_oe, 1'b0)
        $display("reset done");
        for (r = 0; r < 4; r++) begin
            range_select_pin <= rows[r][48];
            conv(rows[r][47:24]);
            rd(24);
            `CHK(got[23:0], rows[r][23:0])
            $display("row %0d done", r);
        end
        rd_n <= 1'b1;
        range_select_pin <= 1'b1;
        conv(24'h3C0FF0);
        `CHK(sdo_oe, 1'b0)
        rd(24);
        rd_n <= 1'b0;
        repeat (8) @(posedge clk);
        rd(24);
        `CHK(got[23:0], 24'h3C0FF0)
        $display("gated read done");
        chain_sel <= 1'b1;
        conv(24'h5A0001);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        rd(48);
        `CHK(got, {24'h5A0001, 24'hA5C30F})
        $display("chain read done");
        complete_run;
    end
endmodule // tb_sar_adc_serial_readout
